// ==== verilog/mode_ctrl_pkg.sv ====
// constants for the mode register and pattern readout control block
package mode_ctrl_pkg;
   localparam int          MR_W          = 22;
   localparam logic [2:0]  MR3_SEL       = 3'h3;
   localparam logic [2:0]  MR4_SEL       = 3'h4;
   // field positions, third config register
   localparam int          MR3_PAGE_LSB  = 0;
   localparam int          MR3_PR_EN     = 2;
   localparam int          MR3_GEAR      = 3;
   localparam int          MR3_PDA       = 4;
   localparam int          MR3_TEMP      = 5;
   localparam int          MR3_WCL_LSB   = 9;
   localparam int          MR3_FMT_LSB   = 11;
   // field positions, fourth config register
   localparam int          MR4_SRA       = 9;
   localparam int          MR4_RPT       = 10;
   localparam int          MR4_RPRE      = 11;
   localparam int          MR4_WPRE      = 12;
   localparam int          MR4_PPR       = 13;
   // implemented bits; reserved and omitted fields store zero
   localparam logic [21:0] MR3_MASK      = 22'h001e3f;
   localparam logic [21:0] MR4_MASK      = 22'h003e00;
   // reset values carry the select code in bits 20:18
   localparam logic [21:0] MR3_RESET     = 22'h0c0000;
   localparam logic [21:0] MR4_RESET     = 22'h100000;
   // readout formats and codes
   localparam logic [1:0]  FMT_SERIAL    = 2'h0;
   localparam logic [1:0]  FMT_PARALLEL  = 2'h1;
   localparam logic [1:0]  FMT_STAGGER   = 2'h2;
   localparam logic [1:0]  CODE_RSVD     = 2'h3;
   localparam logic [1:0]  PAGE_STATUS   = 2'h2;
   localparam logic [1:0]  PAGE_VENDOR   = 2'h3;
   localparam logic [2:0]  WCL_BASE_CLKS = 3'h4;
   localparam logic [2:0]  BURST_LAST    = 3'h7;
   localparam logic [63:0] PATTERN_RESET = 64'h00ff_00ff_55aa_55aa;
   // temperature status refresh
   localparam int          TEMP_PERIOD_MS = 32;
   localparam int          CLK_HZ         = 25000000;
   localparam int          TEMP_CYCLES    = TEMP_PERIOD_MS * (CLK_HZ / 1000);
   localparam int          STATUS_W       = 16;
   typedef enum logic [1:0] {
      GEAR_HALF    = 2'b00,
      GEAR_ARMED   = 2'b01,
      GEAR_QUARTER = 2'b11
   } gear_e;
endpackage

// ==== verilog/mode_register_mpr_control.sv ====
// mode register decode, pattern readout and mode status of the memory device
// How it works
// - mode register set writing bit 2 of third register enters pattern readout
// - readout data is formatted by bits 12:11 of the third register
// - in readout mode reads return the addressed mode location, not the array
// - each mode register is read as lower and upper bytes, one burst each; bits 21:16 read at location 3
// - reset is accepted in readout mode; full initialisation follows
// - temperature status lands in bits 4:3 of page 2 location 0
// - temperature status is refreshed at least every 32 ms
// - per-device mode masks mode register set while dq0 is high
// - starts half rate; mode set plus sync pulse enters quarter rate
// - fourth register written by mode set with bank and address mapping
// - bit 13 of fourth register enables permanent row repair
// - bit 12 selects one or two clock write preamble
// - bit 11 selects read preamble length, bit 10 enables its training
// - bit 9 enables self refresh abort
// - format 00 serial, 01 parallel, 10 staggered, 11 reserved
// - bits 1:0 select readout page; page 3 reads as zero
// - bit 3 selects half rate or quarter rate clock ratio
// - latency code 00, 01, 10 give 4, 5, 6 clocks; 11 reserved
`timescale 1ns/1ps
module mode_register_mpr_control
   import mode_ctrl_pkg::*;
#(
   parameter int          TEMP_CYCLES_P = TEMP_CYCLES,
   parameter logic [63:0] PATTERN_INIT  = PATTERN_RESET
)(
   input  logic                clk,
   input  logic                reset,
   input  logic                ck,
   input  logic                reset_n,
   input  logic                cs_n,
   input  logic                ras_n,
   input  logic                cas_n,
   input  logic                we_n,
   input  logic [1:0]          bg,
   input  logic [1:0]          ba,
   input  logic [17:0]         addr,
   input  logic [7:0]          dq_in,
   input  logic [1:0]          temp_sensor,
   output logic [7:0]          dq_out,
   output logic                dq_oe,
   output logic                array_read,
   output logic                array_write,
   output logic                pattern_readout_active,
   output logic [1:0]          read_format,
   output logic [1:0]          readout_page,
   output logic [2:0]          extra_write_latency,
   output logic                temp_status_enable,
   output logic                per_device_enable,
   output logic                quarter_rate_clocking,
   output logic                permanent_row_repair,
   output logic                write_preamble_two,
   output logic                read_preamble_two,
   output logic                read_preamble_training,
   output logic                self_refresh_abort
);

////////////////////////////////////////////////////////////////////////////////
// link side reset: core reset and the device reset pin, both synchronised
   logic [1:0]          core_rst_sync;
   logic [1:0]          pin_rst_sync;
   wire                 ck_rst = core_rst_sync[1] | ~pin_rst_sync[1];

   always_ff @(posedge ck) begin
      core_rst_sync <= {core_rst_sync[0], reset};
      pin_rst_sync  <= {pin_rst_sync[0], reset_n};
   end

////////////////////////////////////////////////////////////////////////////////
// command decode
   logic [21:0]         third_config_register;
   logic [21:0]         fourth_config_register;
   gear_e               gear;
   gear_e               next_gear;

   wire                 is_mrs = ~cs_n & ~ras_n & ~cas_n & ~we_n;
   wire                 is_rd  = ~cs_n & ras_n & ~cas_n & we_n;
   wire                 is_wr  = ~cs_n & ras_n & ~cas_n & ~we_n;
   wire                 is_nop = ~cs_n & ras_n & cas_n & we_n;
   wire [2:0]           mr_sel = {bg[0], ba};
   // bits 16:14 have no pin during mode set
   wire [21:0]          mr_image = {bg, ba, addr[17], 3'h0, addr[13:0]};
   wire                 pda_block = third_config_register[MR3_PDA] & dq_in[0];
   wire                 mrs_ok = is_mrs & ~pda_block;
   wire                 wr_mr3 = mrs_ok & (mr_sel == MR3_SEL);
   wire                 wr_mr4 = mrs_ok & (mr_sel == MR4_SEL);
   wire                 pr_active = third_config_register[MR3_PR_EN];
   wire [1:0]           page = third_config_register[MR3_PAGE_LSB +: 2];
   wire [1:0]           fmt = third_config_register[MR3_FMT_LSB +: 2];

////////////////////////////////////////////////////////////////////////////////
// mode registers; reserved codes keep the previous setting
   wire [21:0]          mr3_in = (mr_image & MR3_MASK) | MR3_RESET;
   wire [21:0]          mr4_in = (mr_image & MR4_MASK) | MR4_RESET;
   wire                 fmt_bad = mr3_in[MR3_FMT_LSB +: 2] == CODE_RSVD;
   wire                 wcl_bad = mr3_in[MR3_WCL_LSB +: 2] == CODE_RSVD;
   wire [1:0]           next_fmt = fmt_bad ? fmt : mr3_in[12:11];
   wire [1:0]           next_wcl = wcl_bad ? third_config_register[10:9]
                                           : mr3_in[10:9];
   wire [21:0]          next_mr3 = {mr3_in[21:13], next_fmt, next_wcl, mr3_in[8:0]};

   always_ff @(posedge ck) begin
      if (ck_rst) begin
         third_config_register  <= MR3_RESET;
         fourth_config_register <= MR4_RESET;
      end else begin
         if (wr_mr3) begin
            third_config_register <= next_mr3;
         end
         if (wr_mr4) begin
            fourth_config_register <= mr4_in;
         end
      end
   end

////////////////////////////////////////////////////////////////////////////////
// gear-down: armed by mode set, taken on the sync pulse
   always_comb begin
      next_gear = gear;
      case (gear)
         GEAR_HALF: begin
            if (wr_mr3 && mr_image[MR3_GEAR]) begin
               next_gear = GEAR_ARMED;
            end
         end
         GEAR_ARMED: begin
            if (wr_mr3 && !mr_image[MR3_GEAR]) begin
               next_gear = GEAR_HALF;
            end else if (is_nop) begin
               next_gear = GEAR_QUARTER;
            end
         end
         GEAR_QUARTER: begin
            if (wr_mr3 && !mr_image[MR3_GEAR]) begin
               next_gear = GEAR_HALF;
            end
         end
         default: begin
            next_gear = GEAR_HALF;
         end
      endcase
   end

   always_ff @(posedge ck) begin
      if (ck_rst) begin
         gear <= GEAR_HALF;
      end else begin
         gear <= next_gear;
      end
   end

////////////////////////////////////////////////////////////////////////////////
// pattern store: pages 0 and 1, written from the address pins in readout mode
   logic [7:0]          pattern [8];
   wire [2:0]           pat_idx = {page[0], addr[1:0]};
   wire                 pat_we = is_wr & pr_active & ~page[1];

   for (genvar e = 0; e < 8; e++) begin : g_pat
      always_ff @(posedge ck) begin
         if (ck_rst) begin
            pattern[e] <= PATTERN_INIT[8*e +: 8];
         end else if (pat_we && pat_idx == 3'(e)) begin
            pattern[e] <= addr[7:0];
         end
      end
   end

////////////////////////////////////////////////////////////////////////////////
// readout byte: location from a1:a0, half from a2
   logic [1:0]          temp_val;
   wire                 half_hi = addr[2];
   wire [1:0]           temp_bits = third_config_register[MR3_TEMP] ? temp_val : 2'h0;
   wire [7:0]           status_loc0 = {3'h0, temp_bits, 3'h0};
   wire [7:0]           mr3_half = half_hi ? third_config_register[15:8]
                                           : third_config_register[7:0];
   wire [7:0]           mr4_half = half_hi ? fourth_config_register[15:8]
                                           : fourth_config_register[7:0];
   wire [7:0]           top_half = half_hi ? {2'h0, fourth_config_register[21:16]}
                                           : {2'h0, third_config_register[21:16]};
   wire [7:0]           status_byte = (addr[1:0] == 2'h0) ? status_loc0 :
                                      (addr[1:0] == 2'h1) ? mr3_half :
                                      (addr[1:0] == 2'h2) ? mr4_half : top_half;
   // vendor page reads as zero rather than exposing anything
   wire [7:0]           rd_byte = (page == PAGE_VENDOR) ? 8'h00 :
                                  (page == PAGE_STATUS) ? status_byte :
                                  pattern[pat_idx];

////////////////////////////////////////////////////////////////////////////////
// burst of eight beats
   logic [7:0]          rd_hold;
   logic [2:0]          burst_cnt;
   logic                bursting;
   wire  [7:0]          beat;

   for (genvar i = 0; i < 8; i++) begin : g_lane
      wire [2:0] ser = BURST_LAST - burst_cnt;
      wire [2:0] stg = BURST_LAST - (burst_cnt + 3'(i));
      assign beat[i] = (fmt == FMT_PARALLEL) ? rd_hold[i] :
                       (fmt == FMT_STAGGER)  ? rd_hold[stg] :
                                               rd_hold[ser];
   end

   always_ff @(posedge ck) begin
      if (ck_rst) begin
         rd_hold   <= 8'h00;
         burst_cnt <= 3'h0;
         bursting  <= 1'b0;
      end else if (is_rd && pr_active) begin
         rd_hold   <= rd_byte;
         burst_cnt <= 3'h0;
         bursting  <= 1'b1;
      end else if (bursting) begin
         burst_cnt <= burst_cnt + 3'h1;
         bursting  <= burst_cnt != BURST_LAST;
      end
   end

   always_ff @(posedge ck) begin
      if (ck_rst) begin
         dq_out      <= 8'h00;
         dq_oe       <= 1'b0;
         array_read  <= 1'b0;
         array_write <= 1'b0;
      end else begin
         dq_out      <= bursting ? beat : 8'h00;
         dq_oe       <= bursting;
         array_read  <= is_rd & ~pr_active;
         array_write <= is_wr & ~pr_active;
      end
   end

////////////////////////////////////////////////////////////////////////////////
// status word to the core clock, toggle handshake; held word is stable
   logic [STATUS_W-1:0] stat_hold;
   logic                stat_req;
   logic [1:0]          stat_ack_sync;
   logic [1:0]          stat_req_sync;
   logic                stat_ack;
   logic [STATUS_W-1:0] status;
   wire  [2:0]          wcl_clks = WCL_BASE_CLKS + {1'b0, third_config_register[10:9]};
   wire  [STATUS_W-1:0] stat_now = {
      pr_active, fmt, page, wcl_clks,
      third_config_register[MR3_TEMP], third_config_register[MR3_PDA],
      gear == GEAR_QUARTER,
      fourth_config_register[MR4_PPR],
      fourth_config_register[MR4_WPRE],
      fourth_config_register[MR4_RPRE],
      fourth_config_register[MR4_RPT],
      fourth_config_register[MR4_SRA]
   };
   wire                 stat_idle = stat_req == stat_ack_sync[1];

   always_ff @(posedge ck) begin
      stat_ack_sync <= {stat_ack_sync[0], stat_ack};
      if (ck_rst) begin
         // resend the reset word so the core side never keeps stale modes
         stat_hold <= {5'h0, WCL_BASE_CLKS, 8'h00};
         stat_req  <= ~stat_ack_sync[1];
      end else if (stat_idle && stat_now != stat_hold) begin
         stat_hold <= stat_now;
         stat_req  <= ~stat_req;
      end
   end

   always_ff @(posedge clk) begin
      stat_req_sync <= {stat_req_sync[0], stat_req};
      if (reset) begin
         stat_ack <= 1'b0;
         status   <= '0;
      end else if (stat_req_sync[1] != stat_ack) begin
         stat_ack <= stat_req_sync[1];
         status   <= stat_hold;
      end
   end

   assign pattern_readout_active = status[15];
   assign read_format            = status[14:13];
   assign readout_page           = status[12:11];
   assign extra_write_latency    = status[10:8];
   assign temp_status_enable     = status[7];
   assign per_device_enable      = status[6];
   assign quarter_rate_clocking  = status[5];
   assign permanent_row_repair   = status[4];
   assign write_preamble_two     = status[3];
   assign read_preamble_two      = status[2];
   assign read_preamble_training = status[1];
   assign self_refresh_abort     = status[0];

////////////////////////////////////////////////////////////////////////////////
// temperature sensor sampled on a fixed period, handed to the link side
   logic [1:0]          temp_sync0;
   logic [1:0]          temp_sync1;
   logic [31:0]         temp_cnt;
   logic [1:0]          temp_hold;
   logic                temp_req;
   logic [1:0]          temp_ack_sync;
   logic [1:0]          temp_req_sync;
   logic                temp_ack;
   // tick at zero so a fresh value follows reset at once
   wire                 temp_tick = temp_cnt == 32'h0;

   always_ff @(posedge clk) begin
      temp_sync0    <= temp_sensor;
      temp_sync1    <= temp_sync0;
      temp_ack_sync <= {temp_ack_sync[0], temp_ack};
      if (reset) begin
         temp_cnt  <= 32'h0;
         temp_hold <= 2'h0;
         temp_req  <= 1'b0;
      end else begin
         temp_cnt <= (temp_cnt == 32'(TEMP_CYCLES_P - 1)) ? 32'h0
                                                          : temp_cnt + 32'h1;
         if (temp_tick && temp_req == temp_ack_sync[1]) begin
            temp_hold <= temp_sync1;
            temp_req  <= ~temp_req;
         end
      end
   end

   always_ff @(posedge ck) begin
      temp_req_sync <= {temp_req_sync[0], temp_req};
      if (ck_rst) begin
         temp_ack <= 1'b0;
         temp_val <= 2'h0;
      end else if (temp_req_sync[1] != temp_ack) begin
         temp_ack <= temp_req_sync[1];
         temp_val <= temp_hold;
      end
   end

endmodule

// ==== verification/mode_ctrl_sva.sv ====
// port checks for the mode register and pattern readout block
`timescale 1ns/1ps
module mode_ctrl_sva
   import mode_ctrl_pkg::*;
(
   input wire logic        clk,
   input wire logic        reset,
   input wire logic        ck,
   input wire logic        reset_n,
   input wire logic        cs_n,
   input wire logic        ras_n,
   input wire logic        cas_n,
   input wire logic        we_n,
   input wire logic [1:0]  bg,
   input wire logic [1:0]  ba,
   input wire logic [17:0] addr,
   input wire logic [7:0]  dq_in,
   input wire logic [7:0]  dq_out,
   input wire logic        dq_oe,
   input wire logic        array_read,
   input wire logic        array_write,
   input wire logic [1:0]  read_format,
   input wire logic [2:0]  extra_write_latency
);
   logic pr;
   logic pda;
   wire  mrs = !cs_n && !ras_n && !cas_n && !we_n;
   wire  rd  = !cs_n && ras_n && !cas_n && we_n;
   wire  wr  = !cs_n && ras_n && !cas_n && !we_n;
   // own copy of the mode bits, so checks do not trust the design's state
   wire  m3  = mrs && {bg[0], ba} == MR3_SEL && !(pda && dq_in[0]);
   wire  rdp = rd && pr;
   wire  rdn = rd && !pr;
   always_ff @(posedge ck) begin
      if (reset || !reset_n) begin
         pr  <= 1'b0;
         pda <= 1'b0;
      end else if (m3) begin
         pr  <= addr[MR3_PR_EN];
         pda <= addr[MR3_PDA];
      end
   end
   ////////////////////////////////////////////////////////////
   burst_len_a: assert property (
      @(posedge ck) disable iff (reset || !reset_n) rdp |-> ##2 dq_oe [*8])
      else $error("readout burst shorter than eight beats");
   burst_src_a: assert property (
      @(posedge ck) disable iff (reset || !reset_n) $rose(dq_oe) |-> $past(rdp, 2))
      else $error("burst started without a readout read");
   burst_end_a: assert property (
      @(posedge ck) disable iff (reset || !reset_n) $fell(dq_oe) |-> !$past(rdp, 2))
      else $error("burst ended although a read restarted it");
   array_rd_a: assert property (
      @(posedge ck) disable iff (reset || !reset_n) rdn |=> array_read)
      else $error("normal read did not reach the array");
   no_array_a: assert property (
      @(posedge ck) disable iff (reset || !reset_n) array_read |-> $past(rdn))
      else $error("array read without a normal read");
   array_wr_a: assert property (
      @(posedge ck) disable iff (reset || !reset_n) wr && !pr |=> array_write && !array_read)
      else $error("normal write did not reach the array");
   idle_bus_a: assert property (
      @(posedge ck) disable iff (reset || !reset_n) !dq_oe |-> dq_out == 8'h00)
      else $error("data lanes not quiet outside a burst");
   fmt_code_a: assert property (
      @(posedge clk) disable iff (reset) read_format != CODE_RSVD)
      else $error("reserved readout format shown");
   wcl_code_a: assert property (
      @(posedge clk) disable iff (reset)
      !$stable(extra_write_latency) |-> extra_write_latency inside {3'h4, 3'h5, 3'h6})
      else $error("extra write latency out of range");
endmodule

// ==== verification/ctrl_model.sv ====
// memory controller model driving the command pins on the link clock
`timescale 1ns/1ps
module ctrl_model (
   input  wire logic       ck,
   output logic            reset_n,
   output logic            cs_n,
   output logic            ras_n,
   output logic            cas_n,
   output logic            we_n,
   output logic [1:0]      bg,
   output logic [1:0]      ba,
   output logic [17:0]     addr,
   output logic [7:0]      dq_in,
   input  wire logic [7:0] dq_out,
   input  wire logic       dq_oe
);
   // never opens a row, so all banks stay idle and precharged
   initial begin
      reset_n = 1'b0;
      cs_n    = 1'b1;
      {ras_n, cas_n, we_n} = 3'h7;
      {bg, ba} = 4'h0;
      addr    = 18'h00000;
      dq_in   = 8'hff;
   end
   ////////////////////////////////////////////////////////////
   // deselected lines show the inverse, except bg and ba, which keep the command value
   task automatic issue(input logic [2:0] rcw, input logic [2:0] sel,
                        input logic [17:0] a, input logic dq0);
      @(posedge ck);
      cs_n <= 1'b0;
      {ras_n, cas_n, we_n} <= rcw;
      {bg, ba} <= {1'b0, sel};
      addr <= a & 18'h1ffff;
      dq_in <= {7'h00, dq0};
      @(posedge ck);
      cs_n <= 1'b1;
      {ras_n, cas_n, we_n} <= ~rcw;
      addr <= ~a;
      dq_in <= {7'h7f, ~dq0};
   endtask
   // a nop after the arming mode set is the sync pulse
   task automatic mrs(input logic [2:0] sel, input logic [17:0] a, input logic dq0);
      issue(3'h0, sel, a, dq0);
   endtask
   task automatic rd_burst(input logic [17:0] a, output logic [63:0] b);
      b = 'x;
      issue(3'h5, 3'h0, a, 1'b0);
      for (int i = 0; i < 8 && dq_oe !== 1'b1; i++)
         @(posedge ck);
      for (int n = 0; n < 8; n++) begin
         b[8*n +: 8] = dq_out;
         @(posedge ck);
      end
   endtask
   task automatic pulse_reset();
      @(posedge ck);
      reset_n <= 1'b0;
      repeat (4) @(posedge ck);
      reset_n <= 1'b1;
      repeat (4) @(posedge ck);
   endtask
endmodule

// ==== verification/mode_register_mpr_control_bench.sv ====
// self-checking bench for the mode register and pattern readout block
`timescale 1ns/1ps
module mode_register_mpr_control_bench;
   import mode_ctrl_pkg::*;
   logic        clk, reset, ck, reset_n, cs_n, ras_n, cas_n, we_n;
   logic [1:0]  bg, ba, temp_sensor, read_format, readout_page;
   logic [17:0] addr;
   logic [7:0]  dq_in, dq_out;
   logic [2:0]  extra_write_latency;
   logic        dq_oe, array_read, array_write, pattern_readout_active;
   logic        temp_status_enable, per_device_enable, quarter_rate_clocking;
   logic        permanent_row_repair, write_preamble_two, read_preamble_two;
   logic        read_preamble_training, self_refresh_abort;
   int          error_cnt, n_checks;
   mode_register_mpr_control #(.TEMP_CYCLES_P(64)) dut (.clk, .reset, .ck, .reset_n,
      .cs_n, .ras_n, .cas_n, .we_n, .bg, .ba, .addr, .dq_in, .temp_sensor, .dq_out,
      .dq_oe, .array_read, .array_write, .pattern_readout_active, .read_format,
      .readout_page, .extra_write_latency, .temp_status_enable, .per_device_enable,
      .quarter_rate_clocking, .permanent_row_repair, .write_preamble_two,
      .read_preamble_two, .read_preamble_training, .self_refresh_abort);
   ctrl_model m (.ck, .reset_n, .cs_n, .ras_n, .cas_n, .we_n, .bg, .ba, .addr,
      .dq_in, .dq_out, .dq_oe);
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      ck = 1'b0;
      #7;
      forever #32 ck = ~ck;
   end
   ////////////////////////////////////////////////////////////
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // status crosses domains with no handshake at the ports
   task automatic settle();
      repeat (20) @(posedge clk);
   endtask
   function automatic logic [63:0] exp_burst(input logic [7:0] v, input logic [1:0] f);
      logic [63:0] r;
      for (int n = 0; n < 8; n++)
         for (int i = 0; i < 8; i++)
            r[8*n+i] = f == FMT_SERIAL ? v[7-n] : f == FMT_PARALLEL ? v[i] : v[(15-n-i)%8];
      return r;
   endfunction
   task automatic wrap_up();
      if (error_cnt == 0 && n_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      #400000;
      error_cnt++;
      wrap_up();
   end
   ////////////////////////////////////////////////////////////
   initial begin
      logic [63:0] b;
      logic [17:0] pa [7];
      logic [7:0]  pe [7];
      pa = '{18'h1, 18'h5, 18'h3, 18'h7, 18'h6, 18'h2, 18'h0};
      pe = '{8'h26, 8'h08, 8'h0c, 8'h10, 8'h3e, 8'h00, 8'h08};
      reset = 1'b1;
      temp_sensor = 2'h2;
      error_cnt = 0;
      n_checks = 0;
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      m.pulse_reset();
      settle();
      chk({pattern_readout_active, read_format, readout_page, temp_status_enable,
           per_device_enable, quarter_rate_clocking, permanent_row_repair,
           write_preamble_two, read_preamble_two, read_preamble_training,
           self_refresh_abort}, 64'h0);
      chk(extra_write_latency, 3'h4);
      m.issue(3'h5, 3'h0, 18'h0, 1'b0);
      m.issue(3'h4, 3'h0, 18'h1, 1'b0);
      for (int c = 0; c < 4; c++) begin
         m.mrs(MR3_SEL, {7'h0, c[1:0], 9'h000}, 1'b0);
         settle();
         chk(extra_write_latency, c < 3 ? 3'h4 + c[2:0] : 3'h6);
      end
      m.mrs(MR3_SEL, 18'h8, 1'b0);
      settle();
      chk(quarter_rate_clocking, 1'b0);
      m.issue(3'h7, 3'h0, 18'h0, 1'b0);
      settle();
      chk(quarter_rate_clocking, 1'b1);
      m.mrs(MR3_SEL, 18'h0, 1'b0);
      settle();
      chk(quarter_rate_clocking, 1'b0);
      for (int k = 9; k < 14; k++) begin
         m.mrs(MR4_SEL, 18'h1 << k, 1'b0);
         settle();
         chk({permanent_row_repair, write_preamble_two, read_preamble_two,
              read_preamble_training, self_refresh_abort}, 5'h1 << (k - 9));
      end
      m.mrs(MR4_SEL, 18'h3e00, 1'b0);
      m.mrs(MR3_SEL, 18'h10, 1'b0);
      settle();
      chk(per_device_enable, 1'b1);
      m.mrs(MR3_SEL, 18'h14, 1'b1);
      settle();
      chk(pattern_readout_active, 1'b0);
      for (int f = 0; f < 4; f++) begin
         m.mrs(MR3_SEL, {5'h0, f[1:0], 11'h004}, 1'b0);
         m.rd_burst(18'h1, b);
         settle();
         chk(read_format, f < 3 ? f[1:0] : FMT_STAGGER);
         chk(b, exp_burst(PATTERN_RESET[15:8], f < 3 ? f[1:0] : FMT_STAGGER));
      end
      m.mrs(MR3_SEL, 18'h0805, 1'b0);
      m.rd_burst(18'h2, b);
      chk(b, exp_burst(PATTERN_RESET[55:48], FMT_PARALLEL));
      m.issue(3'h4, 3'h0, 18'h3e, 1'b0);
      m.rd_burst(18'h2, b);
      chk(b, exp_burst(8'h3e, FMT_PARALLEL));
      m.mrs(MR3_SEL, 18'h0807, 1'b0);
      m.rd_burst(18'h0, b);
      chk(b, 64'h0);
      m.mrs(MR3_SEL, 18'h0826, 1'b0);
      m.rd_burst(18'h0, b);
      chk(b, exp_burst(8'h10, FMT_PARALLEL));
      @(posedge clk);
      temp_sensor <= 2'h1;
      repeat (100) @(posedge clk);
      chk({temp_status_enable, readout_page}, 3'h6);
      foreach (pa[k]) begin
         m.rd_burst(pa[k], b);
         chk(b, exp_burst(pe[k], FMT_PARALLEL));
      end
      m.mrs(MR3_SEL, 18'h0, 1'b0);
      m.issue(3'h5, 3'h0, 18'h0, 1'b0);
      settle();
      chk(pattern_readout_active, 1'b0);
      m.mrs(MR3_SEL, 18'h4, 1'b0);
      settle();
      chk(pattern_readout_active, 1'b1);
      m.pulse_reset();
      settle();
      chk({pattern_readout_active, permanent_row_repair}, 2'h0);
      wrap_up();
   end
endmodule
bind mode_register_mpr_control mode_ctrl_sva sva (.clk, .reset, .ck, .reset_n, .cs_n,
   .ras_n, .cas_n, .we_n, .bg, .ba, .addr, .dq_in, .dq_out, .dq_oe, .array_read,
   .array_write, .read_format, .extra_write_latency);
